// File: pkg/pll_swo_pkg.sv
// shared constants, types and register map of the reference switchover controller
package pll_swo_pkg;
	// ==================== register map (byte addresses)
	localparam logic [4:0] CONTROL_OFS = 5'h00;
	localparam logic [4:0] STATUS_OFS = 5'h04;
	localparam logic [4:0] LOSS_LIMIT_OFS = 5'h08;
	localparam logic [4:0] FIRST_COUNT_OFS = 5'h0C;
	localparam logic [4:0] SECOND_COUNT_OFS = 5'h10;
	// ==================== control fields
	localparam int CTL_PLL_RESET = 0;
	localparam int CTL_PFD_ENABLE = 1;
	localparam int CTL_MODE_LSB = 2;
	localparam int CTL_SWITCH_REQ = 4;
	// ==================== status fields
	localparam int STS_BAD0 = 0;
	localparam int STS_BAD1 = 1;
	localparam int STS_ACTIVE = 2;
	localparam int STS_LOCKED = 3;
	localparam int STS_BUSY = 4;
	localparam int STS_CASCADE = 5;
	// ==================== reset values and timing
	localparam logic [1:0] MODE_RESET = 2'h1;
	localparam logic [15:0] LOSS_LIMIT_RESET = 16'h0040;
	localparam logic [7:0] COUNT_HIGH_RESET = 8'h02;
	localparam logic [7:0] COUNT_LOW_RESET = 8'h02;
	localparam logic [2:0] SWITCH_HOLD_EDGES = 3'h3;
	localparam logic [4:0] LOCK_EDGES = 5'h10;
	localparam logic [8:0] COUNT_ONE = 9'h001;
	localparam logic [8:0] COUNT_FULL = 9'h100;

	typedef enum logic [1:0] {
		MODE_MANUAL = 2'b00,
		MODE_AUTO = 2'b01,
		MODE_AUTO_OVERRIDE = 2'b10
	} switch_mode_t;

	typedef enum logic [1:0] {
		SW_STEADY = 2'b00,
		SW_GATE_OLD = 2'b01,
		SW_WAIT_NEW = 2'b10
	} switch_state_t;

	typedef struct packed {
		logic [7:0] low_count;
		logic [7:0] high_count;
	} counter_cfg_t;

	typedef struct packed {
		logic [4:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} avalon_req_t;
endpackage

// File: logic/pll_clock_switchover_control.sv
// reference clock switchover, pll reset/lock model and post-scale counters with an avalon-mm slave
// Functional notes
// - chained output counters divide the oscillator by the product of both settings
// - chaining comes from the configuration image only, never from register writes
// - duty cycle set by separate high and low counts per counter
// - disabled phase detector freezes the loop; oscillator free-runs at last frequency
// - pll reset clears counters, outputs and lock, returns oscillator to nominal
// - after pll reset, resynchronise to selected reference and relock before lock rises
// - lock indicator high only when feedback matches reference in phase and frequency
// - automatic mode watches the selected reference and switches when it stops
// - manual request rise held three reference cycles swaps the reference
// - in override mode the manual request beats the automatic decision
// - automatic switching repeats without limit whenever the other input is alive
// - no switchover when both inputs are stopped
// - one failure flag per input, raised when that input is seen stopped
// - an indicator shows which input feeds the pll
// - selected input stuck low raises its failure flag and steers towards backup
// - switchover happens on a falling edge of the still available input
// - manual switch gates output at old falling edge, switches at new falling edge
// - after reset the primary reference is selected
// - only rising edges of the switch request count; falling edges never switch
// - switching waits until the target input is available
`timescale 1ns/1ns
module pll_clock_switchover_control #(
	parameter logic cascade_enable = 1'b0
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic primary_reference_clock,
	input wire logic backup_reference_clock,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic reference_out,
	output logic first_output_counter_clk,
	output logic second_output_counter_clk,
	output logic locked,
	output logic [1:0] clock_bad,
	output logic active_clock
);
	import pll_swo_pkg::*;

	// full 9-bit count, a zero field standing for 256
	function automatic logic [8:0] count_value(input logic [7:0] field);
		count_value = (field == 8'h00) ? COUNT_FULL : {1'b0, field};
	endfunction

	// ==================== register bus
	avalon_req_t req;
	logic pll_reset_reg;
	logic pfd_enable_reg;
	switch_mode_t mode_reg;
	logic switch_req_reg;
	logic [15:0] loss_limit_reg;
	counter_cfg_t first_cfg_reg;
	counter_cfg_t second_cfg_reg;
	logic [31:0] readdata_reg;
	logic waitrequest_reg;
	logic bus_commit;
	logic [31:0] status_word;
	switch_state_t state_reg;

	assign req = '{address: address, read: read, write: write, writedata: writedata};
	// a request is answered one edge after it is seen; it commits when waitrequest is low
	assign bus_commit = (req.read || req.write) && !waitrequest_reg;

	// one wait state per access keeps the address decode out of the readdata path
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			waitrequest_reg <= 1'b1;
		end else begin
			waitrequest_reg <= !((req.read || req.write) && waitrequest_reg);
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			pll_reset_reg <= 1'b0;
			pfd_enable_reg <= 1'b1;
			mode_reg <= switch_mode_t'(MODE_RESET);
			switch_req_reg <= 1'b0;
			loss_limit_reg <= LOSS_LIMIT_RESET;
			first_cfg_reg <= '{low_count: COUNT_LOW_RESET, high_count: COUNT_HIGH_RESET};
			second_cfg_reg <= '{low_count: COUNT_LOW_RESET, high_count: COUNT_HIGH_RESET};
		end else if (bus_commit && req.write) begin
			case (req.address)
				CONTROL_OFS: begin
					pll_reset_reg <= req.writedata[CTL_PLL_RESET];
					pfd_enable_reg <= req.writedata[CTL_PFD_ENABLE];
					mode_reg <= switch_mode_t'(req.writedata[CTL_MODE_LSB +: 2]);
					switch_req_reg <= req.writedata[CTL_SWITCH_REQ];
				end
				LOSS_LIMIT_OFS: loss_limit_reg <= req.writedata[15:0];
				// counts may be rewritten at run time, chaining may not
				FIRST_COUNT_OFS: first_cfg_reg <= counter_cfg_t'(req.writedata[15:0]);
				SECOND_COUNT_OFS: second_cfg_reg <= counter_cfg_t'(req.writedata[15:0]);
				default: begin
				end
			endcase
		end
	end

	assign status_word = {26'h0, cascade_enable, (state_reg != SW_STEADY), locked, active_clock, clock_bad};

	// read data is captured on the first edge so it stands at the committing edge
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			readdata_reg <= 32'h0;
		end else if (req.read && waitrequest_reg) begin
			case (req.address)
				CONTROL_OFS: readdata_reg <= {27'h0, switch_req_reg, mode_reg, pfd_enable_reg, pll_reset_reg};
				STATUS_OFS: readdata_reg <= status_word;
				LOSS_LIMIT_OFS: readdata_reg <= {16'h0, loss_limit_reg};
				FIRST_COUNT_OFS: readdata_reg <= {16'h0, first_cfg_reg};
				SECOND_COUNT_OFS: readdata_reg <= {16'h0, second_cfg_reg};
				default: readdata_reg <= 32'h0;
			endcase
		end
	end

	assign readdata = readdata_reg;
	assign waitrequest = waitrequest_reg;

	// ==================== reference sampling and clock sense
	logic [1:0] ref_now_reg;
	logic [1:0] ref_prev_reg;
	logic [1:0] ref_fall;
	logic [1:0] ref_rise;
	logic [15:0] idle0_reg;
	logic [15:0] idle1_reg;
	logic [1:0] bad_reg;

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ref_now_reg <= 2'b00;
			ref_prev_reg <= 2'b00;
		end else begin
			ref_now_reg <= {backup_reference_clock, primary_reference_clock};
			ref_prev_reg <= ref_now_reg;
		end
	end

	assign ref_fall = ref_prev_reg & ~ref_now_reg;
	assign ref_rise = ~ref_prev_reg & ref_now_reg;

	// an input is stopped once no edge is seen for loss_limit mclk cycles
	// the flags only mean something while both inputs run at similar rates
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			idle0_reg <= 16'h0;
			idle1_reg <= 16'h0;
			bad_reg <= 2'b00;
		end else begin
			idle0_reg <= (ref_fall[0] || ref_rise[0]) ? 16'h0 : (idle0_reg == loss_limit_reg) ? idle0_reg : idle0_reg + 16'h1;
			idle1_reg <= (ref_fall[1] || ref_rise[1]) ? 16'h0 : (idle1_reg == loss_limit_reg) ? idle1_reg : idle1_reg + 16'h1;
			bad_reg[0] <= (idle0_reg == loss_limit_reg);
			bad_reg[1] <= (idle1_reg == loss_limit_reg);
		end
	end

	assign clock_bad = bad_reg;

	// ==================== manual switch request qualification
	logic req_prev_reg;
	logic req_armed_reg;
	logic [2:0] req_edges_reg;
	logic manual_fire;
	logic sel_reg;

	// counting edges of the selected input means a slower clock stretches the hold time
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			req_prev_reg <= 1'b0;
			req_armed_reg <= 1'b0;
			req_edges_reg <= 3'h0;
		end else begin
			req_prev_reg <= switch_req_reg;
			if (!switch_req_reg) begin
				req_armed_reg <= 1'b0;
				req_edges_reg <= 3'h0;
			end else if (!req_prev_reg) begin
				req_armed_reg <= (mode_reg == MODE_MANUAL) || (mode_reg == MODE_AUTO_OVERRIDE);
				req_edges_reg <= 3'h0;
			end else if (manual_fire) begin
				req_armed_reg <= 1'b0;
			end else if (req_armed_reg && ref_rise[sel_reg]) begin
				req_edges_reg <= req_edges_reg + 3'h1;
			end
		end
	end

	assign manual_fire = req_armed_reg && (req_edges_reg == SWITCH_HOLD_EDGES);

	// ==================== switchover state machine
	logic gate_reg;
	logic active_reg;
	logic auto_fire;
	logic manual_pending;

	// a held manual request in override mode keeps the automatic path quiet
	assign manual_pending = (mode_reg == MODE_AUTO_OVERRIDE) && switch_req_reg;
	// both dead: nothing to switch to
	assign auto_fire = ((mode_reg == MODE_AUTO) || ((mode_reg == MODE_AUTO_OVERRIDE) && !manual_pending))
		&& bad_reg[sel_reg] && !bad_reg[!sel_reg];

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_reg <= SW_STEADY;
			sel_reg <= 1'b0;
			gate_reg <= 1'b0;
			active_reg <= 1'b0;
		end else begin
			case (state_reg)
				SW_STEADY: begin
					if (manual_fire) begin
						state_reg <= SW_GATE_OLD;
					end else if (auto_fire) begin
						gate_reg <= 1'b1;
						state_reg <= SW_WAIT_NEW;
					end
				end
				SW_GATE_OLD: begin
					if (ref_fall[sel_reg] || bad_reg[sel_reg]) begin
						gate_reg <= 1'b1;
						state_reg <= SW_WAIT_NEW;
					end
				end
				SW_WAIT_NEW: begin
					// a stopped target never shows a falling edge, so this waits for it
					if (ref_fall[!sel_reg]) begin
						sel_reg <= !sel_reg;
						active_reg <= !sel_reg;
						gate_reg <= 1'b0;
						state_reg <= SW_STEADY;
					end
				end
				default: state_reg <= SW_STEADY;
			endcase
		end
	end

	assign active_clock = active_reg;

	// ==================== reference output and lock model
	logic ref_out_reg;
	logic ref_out_prev_reg;
	logic [4:0] lock_edges_reg;
	logic locked_reg;

	// gating lands before the mux moves, so no runt pulse reaches the output
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			ref_out_reg <= 1'b0;
			ref_out_prev_reg <= 1'b0;
		end else begin
			ref_out_reg <= !gate_reg && ref_now_reg[sel_reg];
			ref_out_prev_reg <= ref_out_reg;
		end
	end

	assign reference_out = ref_out_reg;

	// relock is counted in reference edges; a switch or a dead reference restarts it
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			lock_edges_reg <= 5'h0;
			locked_reg <= 1'b0;
		end else if (pll_reset_reg) begin
			lock_edges_reg <= 5'h0;
			locked_reg <= 1'b0;
		// phase detector off: lock state is frozen and carries no meaning
		end else if (!pfd_enable_reg) begin
			lock_edges_reg <= lock_edges_reg;
			locked_reg <= locked_reg;
		end else if (state_reg != SW_STEADY || bad_reg[sel_reg]) begin
			lock_edges_reg <= 5'h0;
			locked_reg <= 1'b0;
		end else begin
			if (ref_out_reg && !ref_out_prev_reg && lock_edges_reg != LOCK_EDGES) begin
				lock_edges_reg <= lock_edges_reg + 5'h1;
			end
			locked_reg <= (lock_edges_reg == LOCK_EDGES);
		end
	end

	assign locked = locked_reg;

	// ==================== post-scale counters on the oscillator stand-in (mclk)
	logic [8:0] cnt0_reg;
	logic [8:0] cnt1_reg;
	logic out0_reg;
	logic out1_reg;
	logic out0_prev_reg;
	logic tick1;

	always_ff @(posedge mclk) begin
		if (!resetn || pll_reset_reg) begin
			cnt0_reg <= COUNT_ONE;
			out0_reg <= 1'b0;
		end else if (cnt0_reg == COUNT_ONE) begin
			out0_reg <= !out0_reg;
			cnt0_reg <= out0_reg ? count_value(first_cfg_reg.low_count) : count_value(first_cfg_reg.high_count);
		end else begin
			cnt0_reg <= cnt0_reg - COUNT_ONE;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn || pll_reset_reg) begin
			out0_prev_reg <= 1'b0;
		end else begin
			out0_prev_reg <= out0_reg;
		end
	end

	// chained: the second counter advances once per period of the first
	assign tick1 = cascade_enable ? (out0_reg && !out0_prev_reg) : 1'b1;

	always_ff @(posedge mclk) begin
		if (!resetn || pll_reset_reg) begin
			cnt1_reg <= COUNT_ONE;
			out1_reg <= 1'b0;
		end else if (tick1) begin
			if (cnt1_reg == COUNT_ONE) begin
				out1_reg <= !out1_reg;
				cnt1_reg <= out1_reg ? count_value(second_cfg_reg.low_count) : count_value(second_cfg_reg.high_count);
			end else begin
				cnt1_reg <= cnt1_reg - COUNT_ONE;
			end
		end
	end

	assign first_output_counter_clk = out0_reg;
	assign second_output_counter_clk = out1_reg;
endmodule // pll_clock_switchover_control

// File: verification/ref_clk_src.sv
// reference clock pair standing in for the two external sources
`timescale 1ns/1ns
module ref_clk_src (
	input wire logic mclk,
	input wire logic p_run,
	input wire logic b_run,
	output logic primary_reference_clock,
	output logic backup_reference_clock
);
	// ====================
	// 80 ns and 100 ns periods: within a factor of two, as auto mode needs
	logic [2:0] pc = 3'h0;
	logic [2:0] bc = 3'h0;
	initial primary_reference_clock = 1'b0;
	initial backup_reference_clock = 1'b0;
	always @(posedge mclk) begin
		pc <= (pc == 3'h3) ? 3'h0 : pc + 3'h1;
		bc <= (bc == 3'h4) ? 3'h0 : bc + 3'h1;
		// a stopped source rests low
		if (pc == 3'h3) primary_reference_clock <= p_run & ~primary_reference_clock;
		if (bc == 3'h4) backup_reference_clock <= b_run & ~backup_reference_clock;
	end
endmodule // ref_clk_src

// File: verification/swo_chk.sv
// port checker of the switchover controller
`timescale 1ns/1ns
module swo_chk import pll_swo_pkg::*; (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic waitrequest,
	input wire logic reference_out,
	input wire logic first_output_counter_clk,
	input wire logic second_output_counter_clk,
	input wire logic locked,
	input wire logic [1:0] clock_bad,
	input wire logic active_clock
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ==================== control shadow, follows committed writes
	logic [4:0] ctl_reg;
	always_ff @(posedge mclk) begin
		if (!resetn) ctl_reg <= 5'h06;
		else if (write && !waitrequest && address == CONTROL_OFS) ctl_reg <= writedata[4:0];
	end
	// ==================== properties
	property p_wr1; !waitrequest |=> waitrequest; endproperty
	a_wr1: assert property (p_wr1) else $error("wait low too long");
	property p_ans; (read || write) && waitrequest |=> !waitrequest; endproperty
	a_ans: assert property (p_ans) else $error("no bus answer");
	property p_rst; $rose(resetn) |-> !active_clock && clock_bad == 2'h0 && waitrequest; endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	property p_gate; $changed(active_clock) |-> $past(!reference_out); endproperty
	a_gate: assert property (p_gate) else $error("switch not gated");
	property p_both; clock_bad == 2'h3 |=> $stable(active_clock); endproperty
	a_both: assert property (p_both) else $error("switch with both dead");
	property p_prst; ctl_reg[0] ##1 ctl_reg[0] |-> !locked && !first_output_counter_clk && !second_output_counter_clk;
	endproperty
	a_prst: assert property (p_prst) else $error("pll reset ignored");
	property p_lock; $rose(locked) |-> !ctl_reg[0] && !clock_bad[active_clock]; endproperty
	a_lock: assert property (p_lock) else $error("early lock");
	property p_steer; ctl_reg[3:2] == 2'h1 && !active_clock && clock_bad == 2'h1 |-> ##[1:40] active_clock;
	endproperty
	a_steer: assert property (p_steer) else $error("no auto switch");
	c_auto: cover property ($rose(active_clock) && ctl_reg[3:2] == 2'h1);
	c_man: cover property ($rose(active_clock) && ctl_reg[3:2] == 2'h0);
	c_lock: cover property ($rose(locked));
endmodule // swo_chk
bind pll_clock_switchover_control swo_chk chk (.*);

// File: verification/pll_clock_switchover_control_tb_top.sv
// self-checking bench of the switchover controller
`timescale 1ns/1ns
module pll_clock_switchover_control_tb_top;
	import pll_swo_pkg::*;
	typedef struct packed {logic w; logic [4:0] a; logic [31:0] d;} row_t;
	logic mclk = 1'b0;
	logic resetn = 1'b0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [4:0] address = 5'h00;
	logic [31:0] writedata = 32'h0;
	logic p_run = 1'b1;
	logic b_run = 1'b1;
	logic pri, bak, waitrequest, reference_out, fo, so, locked, active_clock;
	logic [1:0] clock_bad;
	logic [31:0] readdata, q;
	int errors = 0;
	int cmp_count = 0;
	int i, a, b;
	// data column is write data, or the expected value of a read
	row_t rows [10] = '{'{1'b0, CONTROL_OFS, 32'h6}, '{1'b0, LOSS_LIMIT_OFS, 32'h40},
		'{1'b0, FIRST_COUNT_OFS, 32'h202}, '{1'b0, SECOND_COUNT_OFS, 32'h202},
		'{1'b1, LOSS_LIMIT_OFS, 32'h8}, '{1'b0, LOSS_LIMIT_OFS, 32'h8}, '{1'b1, 5'h14, 32'hFFFF},
		'{1'b0, 5'h14, 32'h0}, '{1'b1, FIRST_COUNT_OFS, 32'h301}, '{1'b0, FIRST_COUNT_OFS, 32'h301}};
	initial forever #5 mclk = ~mclk;
	ref_clk_src src (.mclk(mclk), .p_run(p_run), .b_run(b_run), .primary_reference_clock(pri),
		.backup_reference_clock(bak));
	pll_clock_switchover_control dut (.mclk(mclk), .resetn(resetn), .primary_reference_clock(pri),
		.backup_reference_clock(bak), .address(address), .read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .reference_out(reference_out),
		.first_output_counter_clk(fo), .second_output_counter_clk(so), .locked(locked),
		.clock_bad(clock_bad), .active_clock(active_clock));
	// ==================== helpers
	task finish_test;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task fail;
		errors++;
		$display("BAD %0t timeout", $time);
		finish_test();
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	// the request stands until the edge that sees waitrequest low
	task automatic bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
		int n;
		@(posedge mclk);
		address <= ad;
		writedata <= d;
		read <= ~w;
		write <= w;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 20) fail();
	endtask
	function logic sel(int k);
		return k == 0 ? active_clock : k == 1 ? locked : clock_bad[1];
	endfunction
	task automatic wt(input int k, input logic v);
		int n;
		n = 0;
		while (sel(k) !== v && n < 900) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 900) fail();
	endtask
	// ==================== sequence
	initial begin
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		for (i = 0; i < 10; i++) begin
			bus(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(q, rows[i].d);
		end
		a = 0;
		b = 0;
		repeat (40) begin
			@(posedge mclk);
			a += (fo === 1'b1);
			b += (so === 1'b1);
		end
		chk(a, 10);
		chk(b, 20);
		bus(1'b1, STATUS_OFS, 32'h3F);
		bus(1'b0, STATUS_OFS, 32'h0);
		chk(q[STS_CASCADE], 1'b0);
		$display("end registers");
		wt(1, 1'b1);
		bus(1'b1, CONTROL_OFS, 32'h7);
		repeat (3) @(posedge mclk);
		chk({locked, fo, so}, 3'h0);
		bus(1'b1, CONTROL_OFS, 32'h6);
		wt(1, 1'b1);
		$display("end pll reset");
		bus(1'b1, CONTROL_OFS, 32'h4);
		p_run <= 1'b0;
		wt(0, 1'b1);
		chk(locked, 1'b1);
		bus(1'b1, CONTROL_OFS, 32'h6);
		bus(1'b0, STATUS_OFS, 32'h0);
		chk(q[2:0], 3'h5);
		p_run <= 1'b1;
		repeat (20) @(posedge mclk);
		b_run <= 1'b0;
		wt(0, 1'b0);
		b_run <= 1'b1;
		repeat (30) @(posedge mclk);
		b_run <= 1'b0;
		wt(2, 1'b1);
		p_run <= 1'b0;
		repeat (60) @(posedge mclk);
		chk(active_clock, 1'b0);
		// primary first, so a lone live backup cannot trigger a failover
		p_run <= 1'b1;
		repeat (20) @(posedge mclk);
		b_run <= 1'b1;
		repeat (30) @(posedge mclk);
		$display("end auto");
		bus(1'b1, CONTROL_OFS, 32'h2);
		bus(1'b1, CONTROL_OFS, 32'h12);
		wt(0, 1'b1);
		bus(1'b1, CONTROL_OFS, 32'h2);
		repeat (100) @(posedge mclk);
		chk(active_clock, 1'b1);
		bus(1'b1, CONTROL_OFS, 32'hA);
		bus(1'b1, CONTROL_OFS, 32'h1A);
		wt(0, 1'b0);
		p_run <= 1'b0;
		repeat (40) @(posedge mclk);
		chk(active_clock, 1'b0);
		p_run <= 1'b1;
		repeat (20) @(posedge mclk);
		bus(1'b1, CONTROL_OFS, 32'h2);
		b_run <= 1'b0;
		repeat (20) @(posedge mclk);
		bus(1'b1, CONTROL_OFS, 32'h12);
		repeat (100) @(posedge mclk);
		chk(active_clock, 1'b0);
		b_run <= 1'b1;
		wt(0, 1'b1);
		$display("end manual");
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		chk(active_clock, 1'b0);
		bus(1'b0, CONTROL_OFS, 32'h0);
		chk(q, 32'h6);
		$display("end reset");
		finish_test();
	end
endmodule // pll_clock_switchover_control_tb_top
